// *** hw/atis_consts.svh ***
`ifndef ATIS_CONSTS_SVH
`define ATIS_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ATIS_OFS_TIMING 8'h00
`define ATIS_OFS_DMA_LEN 8'h04
`define ATIS_OFS_AUX_SEL 8'h08
`define ATIS_OFS_PRI_SEL 8'h0c
`define ATIS_OFS_SCAN_HI 8'h10
`define ATIS_OFS_MODE 8'h14
`define ATIS_OFS_STATUS 8'h18

// ****************************************
// Reset values
// ****************************************
`define ATIS_RST_REG 16'h0000

// ****************************************
// Writable bit masks
// ****************************************
`define ATIS_MASK_TIMING 16'h9fff
`define ATIS_MASK_DMA_LEN 16'h0007
`define ATIS_MASK_AUX_SEL 16'h0707
`define ATIS_MASK_PRI_SEL 16'h9f9f
`define ATIS_MASK_PRI_SEL_LOW16 16'h8f8f
`define ATIS_MASK_MODE 16'h0077

// ****************************************
// Field positions
// ****************************************
`define ATIS_TIM_SRC 15
`define ATIS_TIM_ST_HI 12
`define ATIS_TIM_ST_LO 8
`define ATIS_TIM_DIV_HI 7
`define ATIS_TIM_DIV_LO 0
`define ATIS_DMA_LEN_HI 2
`define ATIS_AUX_NB_HI 10
`define ATIS_AUX_NB_LO 9
`define ATIS_AUX_SB 8
`define ATIS_AUX_NA_HI 2
`define ATIS_AUX_NA_LO 1
`define ATIS_AUX_SA 0
`define ATIS_PRI_NB 15
`define ATIS_PRI_SB_HI 12
`define ATIS_PRI_SB_LO 8
`define ATIS_PRI_NA 7
`define ATIS_PRI_SA_HI 4
`define ATIS_PRI_SA_LO 0
`define ATIS_MODE_TRIG_HI 2
`define ATIS_MODE_TRIG_LO 0
`define ATIS_MODE_12BIT 4
`define ATIS_MODE_ALT 5
`define ATIS_MODE_SCAN 6

// ****************************************
// Codes and counts
// ****************************************
`define ATIS_TRIG_AUTO 3'h7
`define ATIS_DIV_MAX 8'h3f
`define ATIS_NUM_INPUTS 32

`endif

// *** hw/atis_pkg.sv ***
package atis_pkg;

  typedef enum logic [1:0] {
    ATIS_IDLE,
    ATIS_SAMPLE,
    ATIS_CONVERT
  } atis_state_t;

  typedef logic [15:0] atis_reg_t;

  typedef enum logic [2:0] {
    ATIS_SEL_TIMING,
    ATIS_SEL_DMA_LEN,
    ATIS_SEL_AUX,
    ATIS_SEL_PRI,
    ATIS_SEL_SCAN_HI,
    ATIS_SEL_MODE,
    ATIS_SEL_STATUS,
    ATIS_SEL_NONE
  } atis_sel_t;

endpackage

// *** hw/atis_tad_timer.sv ***
`timescale 1ns/1ps
`include "atis_consts.svh"

module atis_tad_timer
  import atis_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  atis_tmr_if.timer tmr
);

  logic [7:0] div_cnt;
  logic [7:0] div_eff;
  logic [4:0] samp_cnt;
  logic running;
  logic tick;

  // Reserved divider codes run at the slowest legal rate rather than wrap.
  assign div_eff = (tmr.divider > `ATIS_DIV_MAX) ? `ATIS_DIV_MAX : tmr.divider;

  // ****************************************
  // Conversion clock
  // ****************************************
  assign tick = tmr.rc_sel ? tmr.rc_tick : (div_cnt == div_eff);
  assign tmr.tad_tick = tick;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 8'h00;
    end else if (tmr.rc_sel || div_cnt >= div_eff) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ****************************************
  // Sample-time counter
  // ****************************************
  assign tmr.elapsed = running && (samp_cnt == 5'h00);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      running <= 1'b0;
      samp_cnt <= 5'h00;
    end else if (tmr.count_start) begin
      running <= 1'b1;
      samp_cnt <= tmr.sample_time;
    end else if (tmr.elapsed) begin
      running <= 1'b0;
    end else if (running && tick) begin
      samp_cnt <= samp_cnt - 5'h01;
    end
  end

endmodule // atis_tad_timer

// *** hw/atis_tmr_if.sv ***
`timescale 1ns/1ps

interface atis_tmr_if;
  logic rc_sel;
  logic [7:0] divider;
  logic [4:0] sample_time;
  logic rc_tick;
  logic count_start;
  logic tad_tick;
  logic elapsed;

  modport core (
    output rc_sel,
    output divider,
    output sample_time,
    output rc_tick,
    output count_start,
    input tad_tick,
    input elapsed
  );

  modport timer (
    input rc_sel,
    input divider,
    input sample_time,
    input rc_tick,
    input count_start,
    output tad_tick,
    output elapsed
  );
endinterface

// *** hw/atis_top.sv ***
// Function
// - Clock source bit picks RC or instruction clock.
// - Sample time equals field value in periods; the code holds sampling one clock longer.
// - Sample time used only with trigger 111.
// - Divider gives period of value plus one; codes above 3F give 64.
// - RC source ignores the divider field.
// - DMA words per input are two^field.
// - Aux negative select: AN9-11, AN6-8 or reference.
// - Aux positive select: AN3-5 or AN0-2.
// - Twelve-bit mode hides aux select fields.
// - Primary negative select: AN1 or reference.
// - Primary positive select picks input by index.
// - Second converter limits primary to AN0-15.
// - Upper scan bits include inputs 16-31.
// - Missing pin converts the negative reference.
// - Unimplemented bits read as zero.
// - Alternate mode switches set A, then B.
// - Scan mask drives primary positive in A.
// - Trigger 111 ends sampling by counter.
`timescale 1ns/1ps
`include "atis_consts.svh"

module atis_top
  import atis_pkg::*;
#(
  parameter int NUM_INPUTS = `ATIS_NUM_INPUTS,
  parameter bit SECOND_CONVERTER = 1'b0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_clock_tick,
  input wire logic start_sample,
  input wire logic ext_sample_end,
  input wire logic conv_done,
  input wire logic [15:0] scan_mask_low,
  output logic conv_start,
  output logic sample_active,
  output logic tad_tick,
  output logic using_set_b,
  output logic [4:0] primary_pos_index,
  output logic primary_pos_to_vref,
  output logic primary_neg_to_an1,
  output logic aux_pos_high,
  output logic [1:0] aux_neg_code,
  output logic [7:0] dma_words_per_input
);

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic atis_sel_t decode(input logic [7:0] addr);
    atis_sel_t sel;
    case (addr)
      `ATIS_OFS_TIMING: sel = ATIS_SEL_TIMING;
      `ATIS_OFS_DMA_LEN: sel = ATIS_SEL_DMA_LEN;
      `ATIS_OFS_AUX_SEL: sel = ATIS_SEL_AUX;
      `ATIS_OFS_PRI_SEL: sel = ATIS_SEL_PRI;
      `ATIS_OFS_SCAN_HI: sel = ATIS_SEL_SCAN_HI;
      `ATIS_OFS_MODE: sel = ATIS_SEL_MODE;
      `ATIS_OFS_STATUS: sel = ATIS_SEL_STATUS;
      default: sel = ATIS_SEL_NONE;
    endcase
    return sel;
  endfunction

  // Lowest selected input at or above start, wrapping past input 31.
  function automatic logic [4:0] first_from(input logic [31:0] mask, input logic [4:0] start);
    logic [4:0] pick;
    logic [4:0] k;
    logic found;
    pick = start;
    found = 1'b0;
    for (int i = 0; i < 32; i++) begin
      k = start + 5'(i);
      if (!found && mask[k]) begin
        pick = k;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  function automatic logic pin_missing(input logic [4:0] idx);
    return {1'b0, idx} >= 6'(NUM_INPUTS);
  endfunction

  // ****************************************
  // Register storage
  // ****************************************
  atis_reg_t conversion_timing_ctrl;
  atis_reg_t dma_buffer_length_ctrl;
  atis_reg_t aux_channel_input_select;
  atis_reg_t primary_channel_input_select;
  atis_reg_t scan_mask_upper;
  atis_reg_t mode_ctrl;
  atis_reg_t status_view;
  atis_reg_t read_value;
  atis_reg_t pri_mask;
  atis_state_t state;
  atis_sel_t rd_sel;
  atis_sel_t wr_sel;
  logic wr_en;
  logic setup_rd;
  logic set_b;
  logic [4:0] scan_ptr;
  logic [31:0] scan_mask_full;
  logic [4:0] scan_pick;
  logic [2:0] sample_end_trigger_sel;
  logic twelve_bit_mode;
  logic alternate_set_enable;
  logic scan_enable;
  logic conv_clock_source_sel;
  logic [4:0] auto_sample_time;
  logic [7:0] conv_clock_divider;
  logic [2:0] dma_words_per_input_code;
  logic sample_end;
  logic next_conv_start;
  logic [4:0] next_pos;
  logic next_neg;
  logic next_aux_pos;
  logic [1:0] next_aux_neg;

  atis_tmr_if tmr ();

  // ****************************************
  // APB slave
  // ****************************************
  // Zero wait states keep software latency flat; unmapped offsets flag an error.
  assign pready = 1'b1;
  assign rd_sel = decode(paddr);
  assign wr_sel = decode(paddr);
  assign pslverr = psel && penable && (decode(paddr) == ATIS_SEL_NONE);
  assign wr_en = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;

  // The second converter only reaches AN0-AN15, so bit 4 of each positive field is absent.
  assign pri_mask = SECOND_CONVERTER ? `ATIS_MASK_PRI_SEL_LOW16 : `ATIS_MASK_PRI_SEL;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      conversion_timing_ctrl <= `ATIS_RST_REG;
    end else if (wr_en && wr_sel == ATIS_SEL_TIMING) begin
      conversion_timing_ctrl <= pwdata[15:0] & `ATIS_MASK_TIMING;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dma_buffer_length_ctrl <= `ATIS_RST_REG;
    end else if (wr_en && wr_sel == ATIS_SEL_DMA_LEN) begin
      dma_buffer_length_ctrl <= pwdata[15:0] & `ATIS_MASK_DMA_LEN;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aux_channel_input_select <= `ATIS_RST_REG;
    end else if (wr_en && wr_sel == ATIS_SEL_AUX && !twelve_bit_mode) begin
      aux_channel_input_select <= pwdata[15:0] & `ATIS_MASK_AUX_SEL;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      primary_channel_input_select <= `ATIS_RST_REG;
    end else if (wr_en && wr_sel == ATIS_SEL_PRI) begin
      primary_channel_input_select <= pwdata[15:0] & pri_mask;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scan_mask_upper <= `ATIS_RST_REG;
    end else if (wr_en && wr_sel == ATIS_SEL_SCAN_HI) begin
      scan_mask_upper <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_ctrl <= `ATIS_RST_REG;
    end else if (wr_en && wr_sel == ATIS_SEL_MODE) begin
      mode_ctrl <= pwdata[15:0] & `ATIS_MASK_MODE;
    end
  end

  assign status_view = {3'h0, scan_ptr, 5'h00, set_b, state};

  always_comb begin
    case (rd_sel)
      ATIS_SEL_TIMING: read_value = conversion_timing_ctrl;
      ATIS_SEL_DMA_LEN: read_value = dma_buffer_length_ctrl;
      ATIS_SEL_AUX: read_value = twelve_bit_mode ? `ATIS_RST_REG : aux_channel_input_select;
      ATIS_SEL_PRI: read_value = primary_channel_input_select;
      ATIS_SEL_SCAN_HI: read_value = scan_mask_upper;
      ATIS_SEL_MODE: read_value = mode_ctrl;
      ATIS_SEL_STATUS: read_value = status_view;
      default: read_value = `ATIS_RST_REG;
    endcase
  end

  // Read data is captured in the setup phase so it comes from a flip-flop in the access phase.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= {16'h0000, read_value};
    end
  end

  // ****************************************
  // Field extraction
  // ****************************************
  assign conv_clock_source_sel = conversion_timing_ctrl[`ATIS_TIM_SRC];
  assign auto_sample_time = conversion_timing_ctrl[`ATIS_TIM_ST_HI:`ATIS_TIM_ST_LO];
  assign conv_clock_divider = conversion_timing_ctrl[`ATIS_TIM_DIV_HI:`ATIS_TIM_DIV_LO];
  assign dma_words_per_input_code = dma_buffer_length_ctrl[`ATIS_DMA_LEN_HI:0];
  assign sample_end_trigger_sel = mode_ctrl[`ATIS_MODE_TRIG_HI:`ATIS_MODE_TRIG_LO];
  assign twelve_bit_mode = mode_ctrl[`ATIS_MODE_12BIT];
  assign alternate_set_enable = mode_ctrl[`ATIS_MODE_ALT];
  assign scan_enable = mode_ctrl[`ATIS_MODE_SCAN];

  // ****************************************
  // Conversion clock and sample timer
  // ****************************************
  assign tmr.rc_sel = conv_clock_source_sel;
  assign tmr.divider = conv_clock_divider;
  assign tmr.sample_time = auto_sample_time;
  assign tmr.rc_tick = rc_clock_tick;
  assign tmr.count_start = start_sample && (state == ATIS_IDLE) && (sample_end_trigger_sel == `ATIS_TRIG_AUTO);
  assign tad_tick = tmr.tad_tick;

  atis_tad_timer u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .tmr(tmr)
  );

  // ****************************************
  // Sample and convert sequence
  // ****************************************
  // Only the counter ends sampling under the auto trigger; otherwise the external event does.
  assign sample_end = (sample_end_trigger_sel == `ATIS_TRIG_AUTO) ? tmr.elapsed : ext_sample_end;
  assign next_conv_start = (state == ATIS_SAMPLE) && sample_end;
  assign sample_active = (state == ATIS_SAMPLE);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ATIS_IDLE;
    end else begin
      case (state)
        ATIS_IDLE: begin
          if (start_sample) begin
            state <= ATIS_SAMPLE;
          end
        end
        ATIS_SAMPLE: begin
          if (sample_end) begin
            state <= ATIS_CONVERT;
          end
        end
        ATIS_CONVERT: begin
          if (conv_done) begin
            state <= ATIS_IDLE;
          end
        end
        default: state <= ATIS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= next_conv_start;
    end
  end

  // Set B follows set A only while alternate mode is on; turning it off returns to A.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      set_b <= 1'b0;
    end else if (!alternate_set_enable) begin
      set_b <= 1'b0;
    end else if (state == ATIS_CONVERT && conv_done) begin
      set_b <= !set_b;
    end
  end

  // ****************************************
  // Input scan
  // ****************************************
  // The second converter has no inputs above AN15, so its upper mask never enters the scan.
  assign scan_mask_full = {SECOND_CONVERTER ? 16'h0000 : scan_mask_upper, scan_mask_low};
  assign scan_pick = first_from(scan_mask_full, scan_ptr);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scan_ptr <= 5'h00;
    end else if (!scan_enable) begin
      scan_ptr <= 5'h00;
    end else if (state == ATIS_CONVERT && conv_done && !set_b) begin
      scan_ptr <= scan_pick + 5'h01;
    end
  end

  // ****************************************
  // Multiplexer selection
  // ****************************************
  always_comb begin
    if (set_b) begin
      next_pos = primary_channel_input_select[`ATIS_PRI_SB_HI:`ATIS_PRI_SB_LO];
      next_neg = primary_channel_input_select[`ATIS_PRI_NB];
      next_aux_pos = aux_channel_input_select[`ATIS_AUX_SB];
      next_aux_neg = aux_channel_input_select[`ATIS_AUX_NB_HI:`ATIS_AUX_NB_LO];
    end else begin
      next_pos = scan_enable ? scan_pick : primary_channel_input_select[`ATIS_PRI_SA_HI:`ATIS_PRI_SA_LO];
      next_neg = primary_channel_input_select[`ATIS_PRI_NA];
      next_aux_pos = aux_channel_input_select[`ATIS_AUX_SA];
      next_aux_neg = aux_channel_input_select[`ATIS_AUX_NA_HI:`ATIS_AUX_NA_LO];
    end
    if (twelve_bit_mode) begin
      next_aux_pos = 1'b0;
      next_aux_neg = 2'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      primary_pos_index <= 5'h00;
      primary_pos_to_vref <= 1'b0;
      primary_neg_to_an1 <= 1'b0;
      aux_pos_high <= 1'b0;
      aux_neg_code <= 2'h0;
      using_set_b <= 1'b0;
    end else begin
      primary_pos_index <= next_pos;
      primary_pos_to_vref <= pin_missing(next_pos);
      primary_neg_to_an1 <= next_neg;
      aux_pos_high <= next_aux_pos;
      aux_neg_code <= next_aux_neg[1] ? next_aux_neg : 2'h0;
      using_set_b <= set_b;
    end
  end

  // ****************************************
  // DMA buffer allocation
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dma_words_per_input <= 8'h01;
    end else begin
      dma_words_per_input <= 8'h01 << dma_words_per_input_code;
    end
  end

endmodule // atis_top

// *** testbench/atis_core_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Converter core and rc oscillator model
// ****************************************
module atis_core_model #(
  parameter int RC_PERIOD = 5
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic conv_start,
  input wire logic [3:0] latency,
  output logic conv_done,
  output logic rc_clock_tick
);
  logic busy;
  logic [3:0] left;
  int rc_count;
  // The oscillator runs free, with no fixed phase to a transfer.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rc_count <= 0;
      rc_clock_tick <= 1'b0;
    end else begin
      rc_count <= (rc_count == RC_PERIOD - 1) ? 0 : rc_count + 1;
      rc_clock_tick <= (rc_count == RC_PERIOD - 1);
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      left <= 4'h0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        busy <= 1'b1;
        left <= latency;
      end else if (busy) begin
        if (left == 4'h0) begin
          conv_done <= 1'b1;
          busy <= 1'b0;
        end else begin
          left <= left - 4'h1;
        end
      end
    end
  end
endmodule // atis_core_model

// *** testbench/atis_properties.sv ***
`timescale 1ns/1ps
`include "atis_consts.svh"
// ****************************************
// Port checker
// ****************************************
module atis_checker #(
  parameter int NUM_INPUTS = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic rc_clock_tick,
  input wire logic start_sample,
  input wire logic conv_start,
  input wire logic sample_active,
  input wire logic tad_tick,
  input wire logic [4:0] primary_pos_index,
  input wire logic primary_pos_to_vref,
  input wire logic [1:0] aux_neg_code,
  input wire logic [7:0] dma_words_per_input
);
  logic wr;
  logic valid;
  logic [15:0] timing;
  logic [2:0] trig;
  logic [2:0] dma;
  logic [7:0] gap;
  logic [7:0] eff;
  logic [5:0] scnt;
  assign wr = psel && penable && pwrite && pready;
  assign eff = (timing[7:0] > `ATIS_DIV_MAX) ? `ATIS_DIV_MAX : timing[7:0];
  // Shadow fields: the checker sees only ports.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      timing <= 16'h0000;
      trig <= 3'h0;
      dma <= 3'h0;
    end else if (wr) begin
      if (paddr == `ATIS_OFS_TIMING) timing <= pwdata[15:0] & `ATIS_MASK_TIMING;
      if (paddr == `ATIS_OFS_MODE) trig <= pwdata[2:0];
      if (paddr == `ATIS_OFS_DMA_LEN) dma <= pwdata[2:0];
    end
  end
  // A tick after a timing write may be irregular; it only arms.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gap <= 8'h00;
      valid <= 1'b0;
      scnt <= 6'h00;
    end else begin
      gap <= tad_tick ? 8'h00 : gap + 8'h01;
      valid <= (wr && paddr == `ATIS_OFS_TIMING) ? 1'b0 : (valid || tad_tick);
      scnt <= sample_active ? scnt + 6'h01 : 6'h00;
    end
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  rc_source_a: assert property (timing[15] && $past(timing[15]) |-> tad_tick == rc_clock_tick)
    else $error("tick not rc");
  div_period_a: assert property (valid && !timing[15] |-> (tad_tick ? gap == eff : gap < eff))
    else $error("tick period");
  auto_time_a: assert property ($fell(sample_active) && trig == 3'h7 && timing[7:0] == 8'h00 && !timing[15]
    |-> scnt == {1'b0, timing[12:8]} + 6'h01) else $error("sample time");
  conv_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start too long");
  conv_cause_a: assert property (conv_start == $fell(sample_active))
    else $error("start misplaced");
  sample_cause_a: assert property ($rose(sample_active) |-> $past(start_sample))
    else $error("no start");
  dma_words_a: assert property ($stable(dma) |-> dma_words_per_input == 8'h01 << dma)
    else $error("buffer words");
  aux_code_a: assert property (aux_neg_code != 2'b01)
    else $error("aux code");
  vref_flag_a: assert property (primary_pos_to_vref == (int'(primary_pos_index) >= NUM_INPUTS))
    else $error("vref flag");
endmodule // atis_checker

bind atis_top atis_checker #(.NUM_INPUTS(NUM_INPUTS)) u_atis_checker (
  .clock,
  .rst_b,
  .psel,
  .penable,
  .pwrite,
  .paddr,
  .pwdata,
  .pready,
  .rc_clock_tick,
  .start_sample,
  .conv_start,
  .sample_active,
  .tad_tick,
  .primary_pos_index,
  .primary_pos_to_vref,
  .aux_neg_code,
  .dma_words_per_input
);

// *** testbench/test_adc_timing_input_select.sv ***
`timescale 1ns/1ps
`include "atis_consts.svh"
module test_adc_timing_input_select;
  localparam int NUM_IN = 24;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic start_sample = 1'b0;
  logic ext_sample_end = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] scan_mask_low = 16'h0000;
  logic [3:0] latency = 4'h1;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, rc_clock_tick, conv_done, conv_start, sample_active, tad_tick, using_set_b;
  logic primary_pos_to_vref, primary_neg_to_an1, aux_pos_high;
  logic [4:0] primary_pos_index;
  logic [1:0] aux_neg_code;
  logic [7:0] dma_words_per_input;
  int failures = 0;
  int total_checks = 0;
  int ns;
  always #25 clock = ~clock;
  atis_top #(.NUM_INPUTS(NUM_IN), .SECOND_CONVERTER(1'b0)) u_atis_top (.clock, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rc_clock_tick, .start_sample, .ext_sample_end, .conv_done,
    .scan_mask_low, .conv_start, .sample_active, .tad_tick, .using_set_b, .primary_pos_index,
    .primary_pos_to_vref, .primary_neg_to_an1, .aux_pos_high, .aux_neg_code, .dma_words_per_input);
  atis_core_model u_atis_core_model (.clock, .rst_b, .conv_start, .latency, .conv_done, .rc_clock_tick);
  // ****************************************
  // Shared tasks
  // ****************************************
  task report_and_stop;
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task fail(input string m);
    failures++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("reg %h exp %h", got, exp));
  endtask
  task chk_out(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("port %h exp %h", got, exp));
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sampling ends by the ext pulse after d cycles, or by the timer when d is 0.
  task conv(input int d, output int s);
    s = 0;
    @(posedge clock);
    start_sample <= 1'b1;
    @(posedge clock);
    start_sample <= 1'b0;
    repeat (d) @(posedge clock);
    if (d > 0) begin
      chk_out(8'(sample_active), 8'h01);
      ext_sample_end <= 1'b1;
      @(posedge clock);
      ext_sample_end <= 1'b0;
    end else begin
      @(posedge clock);
      while (sample_active === 1'b1) begin
        s++;
        @(posedge clock);
      end
    end
    while (conv_done !== 1'b1) @(posedge clock);
    repeat (2) @(posedge clock);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    logic [7:0] a [5];
    logic [15:0] m [5];
    a = '{`ATIS_OFS_TIMING, `ATIS_OFS_DMA_LEN, `ATIS_OFS_AUX_SEL, `ATIS_OFS_PRI_SEL, `ATIS_OFS_SCAN_HI};
    m = '{16'h9fff, 16'h0007, 16'h0707, 16'h9f9f, 16'hffff};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk_reg(rd, 32'h0);
      apb(1'b1, a[i], 32'hffffffff);
      apb(1'b0, a[i], 32'h0);
      chk_reg(rd, {16'h0000, m[i]});
      apb(1'b1, a[i], 32'h0);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk_out(8'(err), 8'h01);
  endtask
  task t_dma;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `ATIS_OFS_DMA_LEN, 32'(c));
      repeat (2) @(posedge clock);
      chk_out(dma_words_per_input, 8'h01 << c);
    end
  endtask
  task t_aux;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      apb(1'b1, `ATIS_OFS_AUX_SEL, 32'(c));
      repeat (2) @(posedge clock);
      chk_out(8'(aux_neg_code), c[2] ? 8'(c[2:1]) : 8'h00);
      chk_out(8'(aux_pos_high), 8'(c[0]));
    end
    apb(1'b1, `ATIS_OFS_AUX_SEL, 32'h0);
    apb(1'b1, `ATIS_OFS_MODE, 32'h10);
    apb(1'b1, `ATIS_OFS_AUX_SEL, 32'h0707);
    apb(1'b0, `ATIS_OFS_AUX_SEL, 32'h0);
    chk_reg(rd, 32'h0);
    apb(1'b1, `ATIS_OFS_MODE, 32'h0);
    apb(1'b0, `ATIS_OFS_AUX_SEL, 32'h0);
    chk_reg(rd, 32'h0);
  endtask
  task t_pri;
    logic [4:0] k [5];
    k = '{5'h00, 5'h05, 5'h17, 5'h18, 5'h1f};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `ATIS_OFS_PRI_SEL, {24'h0, 3'h4, k[i]});
      repeat (2) @(posedge clock);
      chk_out(8'(primary_pos_index), 8'(k[i]));
      chk_out(8'(primary_neg_to_an1), 8'h01);
      chk_out(8'(primary_pos_to_vref), 8'(k[i] >= NUM_IN));
    end
  endtask
  task t_clk;
    logic [15:0] tv [4];
    logic [7:0] ev [4];
    int p;
    tv = '{16'h0002, 16'h003f, 16'h0045, 16'h8002};
    ev = '{8'h03, 8'h40, 8'h40, 8'h05};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `ATIS_OFS_TIMING, {16'h0, tv[i]});
      repeat (2) begin
        @(posedge clock);
        while (tad_tick !== 1'b1) @(posedge clock);
      end
      p = 0;
      do begin
        @(posedge clock);
        p++;
      end while (tad_tick !== 1'b1);
      chk_out(8'(p), ev[i]);
    end
    apb(1'b1, `ATIS_OFS_TIMING, 32'h0);
  endtask
  task t_auto;
    logic [4:0] nv [3];
    nv = '{5'h00, 5'h01, 5'h1f};
    apb(1'b1, `ATIS_OFS_MODE, 32'h7);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `ATIS_OFS_TIMING, {19'h0, nv[i], 8'h00});
      conv(0, ns);
      chk_out(8'(ns), 8'(nv[i]) + 8'h01);
    end
    apb(1'b1, `ATIS_OFS_MODE, 32'h0);
    apb(1'b1, `ATIS_OFS_TIMING, 32'h0300);
    conv(20, ns);
  endtask
  task t_alt;
    logic b;
    latency <= 4'h9;
    apb(1'b1, `ATIS_OFS_MODE, 32'h20);
    apb(1'b1, `ATIS_OFS_PRI_SEL, 32'h0783);
    apb(1'b1, `ATIS_OFS_AUX_SEL, 32'h0506);
    repeat (2) @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      b = i[0];
      chk_out(8'(using_set_b), 8'(b));
      chk_out(8'(primary_pos_index), b ? 8'h07 : 8'h03);
      chk_out(8'(primary_neg_to_an1), b ? 8'h00 : 8'h01);
      chk_out(8'(aux_neg_code), b ? 8'h02 : 8'h03);
      conv(1, ns);
    end
    latency <= 4'h1;
    apb(1'b1, `ATIS_OFS_MODE, 32'h0);
  endtask
  task t_scan;
    logic [4:0] e [4];
    e = '{5'h02, 5'h10, 5'h1f, 5'h02};
    scan_mask_low <= 16'h0004;
    apb(1'b1, `ATIS_OFS_SCAN_HI, 32'h8001);
    apb(1'b1, `ATIS_OFS_PRI_SEL, 32'h0);
    apb(1'b1, `ATIS_OFS_MODE, 32'h40);
    repeat (2) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      chk_out(8'(primary_pos_index), 8'(e[i]));
      chk_out(8'(primary_pos_to_vref), 8'(e[i] >= NUM_IN));
      conv(1, ns);
    end
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    t_regs;
    t_dma;
    t_aux;
    t_pri;
    t_clk;
    t_auto;
    t_alt;
    t_scan;
    report_and_stop;
  end
  // Run needs under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clock);
    fail("timeout");
    report_and_stop;
  end
endmodule // test_adc_timing_input_select
